// ==== src/mhc_top.sv ====
// Operating-hours and service-interval counter with an Avalon-MM register slave.
// Assumes control inputs synchronous to sys_clk_i; times kept in whole minutes.
//
// Local design decisions: the address map and the Avalon-MM slave port.
`include "mhc_map.svh"

module mhc_top #(
    parameter logic [39:0] MINUTE_CYCLES = 40'(64'(`MHC_MINUTE_S) * 64'(`MHC_CLK_HZ))
) (
    input  wire logic                        sys_clk_i,
    input  wire logic                        resetn_i,
    input  wire logic                        monitor_i,
    input  wire logic                        restart_i,
    input  wire logic                        clear_all_i,
    input  wire logic [`MHC_SRC_N*32-1:0]    src_values_i,
    input  wire logic [4:0]                  avs_address_i,
    input  wire logic                        avs_read_i,
    input  wire logic                        avs_write_i,
    input  wire logic [31:0]                 avs_writedata_i,
    input  wire logic [3:0]                  avs_byteenable_i,
    output logic [31:0]                      avs_readdata_o,
    output logic                             avs_waitrequest_o,
    output logic                             service_due_o,
    output logic                             irq_o
);
    logic                        rst_meta;
    logic                        rst_n;
    logic                        restart_rise;
    logic                        clear_rise;
    logic                        minute_tick;
    logic                        ack;
    logic                        wr_en;
    logic                        rd_en;
    logic [31:0]                 next_readdata;
    mhc_pkg::mhc_policy_t        policy;
    logic [`MHC_CTRL_SRC_W-1:0]  src_sel;
    logic [`MHC_INT_HOURS_W-1:0] int_hours;
    logic [`MHC_MINS_W-1:0]      int_mins;
    logic [`MHC_OFS_HOURS_W-1:0] ofs_hours;
    logic [`MHC_MINS_W-1:0]      ofs_mins;
    mhc_pkg::mhc_run_t           accumulated_run_hours;
    mhc_pkg::mhc_remain_t        remaining_time;
    mhc_pkg::mhc_remain_t        service_interval;
    mhc_pkg::mhc_remain_t        const_interval;
    logic [31:0]                 src_value;
    logic                        saturated;
    logic                        clear_cond;
    logic                        due_prev;
    logic                        sat_prev;
    logic [`MHC_IRQ_W-1:0]       irq_stat;
    logic [`MHC_IRQ_W-1:0]       irq_mask;
    logic [`MHC_IRQ_W-1:0]       irq_events;
    logic [31:0]                 wdata;
    logic [31:0]                 cur_word;
    logic [`MHC_INT_HOURS_W-1:0] w_int_hours;
    logic [`MHC_MINS_W-1:0]      w_int_mins;
    logic [`MHC_OFS_HOURS_W-1:0] w_ofs_hours;
    logic [`MHC_MINS_W-1:0]      w_ofs_mins;

    // Reset release through two flops
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    mhc_rise_det u_restart_det (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n),
        .level_i   (restart_i),
        .rise_o    (restart_rise)
    );

    mhc_rise_det u_clear_det (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n),
        .level_i   (clear_all_i),
        .rise_o    (clear_rise)
    );

    // Prescaler runs only on monitor-high time
    mhc_tick_gen #(
        .TICK_CYCLES (MINUTE_CYCLES)
    ) u_tick (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n),
        .enable_i  (monitor_i),
        .tick_o    (minute_tick)
    );

    // Bus handshake: one wait state, access completes on the ack cycle
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
    assign wr_en = avs_write_i & ack;
    assign rd_en = avs_read_i & ack;

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read_i | avs_write_i) & ~ack;
        end
    end

    // Interval in minutes, constant or from another block
    assign const_interval = 20'(int_hours) * 20'(`MHC_MINS_PER_HOUR) + 20'(int_mins);
    always_comb begin
        src_value = 32'h0;
        if (src_sel != '0 && src_sel <= `MHC_CTRL_SRC_W'(`MHC_SRC_N)) begin
            src_value = src_values_i[(int'(src_sel) - 1) * 32 +: 32];
        end
    end
    always_comb begin
        service_interval = const_interval;
        if (src_sel != '0 && src_sel <= `MHC_CTRL_SRC_W'(`MHC_SRC_N)) begin
            // Live value read as minutes, clipped to the largest interval
            if (src_value > 32'(`MHC_INT_MAX_MIN)) begin
                service_interval = `MHC_INT_MAX_MIN;
            end else begin
                service_interval = src_value[19:0];
            end
        end
    end

    // Byte-lane merge of write data onto the current register word
    always_comb begin
        wdata = cur_word;
        for (int b = 0; b < 4; b++) begin
            if (avs_byteenable_i[b]) begin
                wdata[b*8 +: 8] = avs_writedata_i[b*8 +: 8];
            end
        end
    end

    always_comb begin
        case (avs_address_i)
            `MHC_OFF_CTRL: begin
                cur_word = {16'h0, 4'h0, src_sel, 7'h0, policy};
            end
            `MHC_OFF_INTERVAL: begin
                cur_word = {2'h0, int_mins, 10'h0, int_hours};
            end
            `MHC_OFF_OFFSET: begin
                cur_word = {2'h0, ofs_mins, 7'h0, ofs_hours};
            end
            `MHC_OFF_IRQ_MASK: begin
                cur_word = {28'h0, irq_mask};
            end
            default: begin
                cur_word = 32'h0;
            end
        endcase
    end

    // Out-of-range fields are clipped to their largest legal value
    assign w_int_hours = (wdata[13:0] > `MHC_INT_HOURS_MAX) ? `MHC_INT_HOURS_MAX
                                                            : wdata[13:0];
    assign w_int_mins  = (wdata[29:24] > `MHC_MINS_MAX) ? `MHC_MINS_MAX : wdata[29:24];
    assign w_ofs_hours = (wdata[16:0] > `MHC_OFS_HOURS_MAX) ? `MHC_OFS_HOURS_MAX
                                                            : wdata[16:0];
    assign w_ofs_mins  = (wdata[29:24] > `MHC_MINS_MAX) ? `MHC_MINS_MAX : wdata[29:24];

    // Configuration registers
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            policy    <= mhc_pkg::MHC_RESTART_ONLY;
            src_sel   <= '0;
            int_hours <= '0;
            int_mins  <= '0;
            ofs_hours <= '0;
            ofs_mins  <= '0;
            irq_mask  <= '0;
        end else if (wr_en) begin
            case (avs_address_i)
                `MHC_OFF_CTRL: begin
                    policy  <= mhc_pkg::mhc_policy_t'(wdata[`MHC_CTRL_POLICY_BIT]);
                    src_sel <= wdata[`MHC_CTRL_SRC_LSB +: `MHC_CTRL_SRC_W];
                end
                `MHC_OFF_INTERVAL: begin
                    int_hours <= w_int_hours;
                    int_mins  <= w_int_mins;
                end
                `MHC_OFF_OFFSET: begin
                    ofs_hours <= w_ofs_hours;
                    ofs_mins  <= w_ofs_mins;
                end
                `MHC_OFF_IRQ_MASK: begin
                    irq_mask <= wdata[`MHC_IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Run total; an offset write presets it, a full clear zeroes it
    assign saturated = (accumulated_run_hours >= `MHC_RUN_LIMIT_MIN);
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            accumulated_run_hours <= '0;
        end else if (clear_rise) begin
            accumulated_run_hours <= '0;
        end else if (wr_en && avs_address_i == `MHC_OFF_OFFSET) begin
            accumulated_run_hours <= 23'(w_ofs_hours) * 23'(`MHC_MINS_PER_HOUR)
                                   + 23'(w_ofs_mins);
        end else if (minute_tick && !saturated) begin
            // Restart edge has no say here
            accumulated_run_hours <= accumulated_run_hours + 23'h1;
        end
    end

    // Remaining time; a new interval write also reloads it
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            remaining_time <= '0;
        end else if (clear_rise) begin
            remaining_time <= service_interval;
        end else if (restart_rise) begin
            remaining_time <= service_interval;
        end else if (wr_en && avs_address_i == `MHC_OFF_INTERVAL) begin
            remaining_time <= 20'(w_int_hours) * 20'(`MHC_MINS_PER_HOUR) + 20'(w_int_mins);
        end else if (minute_tick && remaining_time != '0) begin
            remaining_time <= remaining_time - 20'h1;
        end
    end

    // Output: clear level wins over the zero condition
    always_comb begin
        clear_cond = restart_i | clear_all_i;
        if (policy == mhc_pkg::MHC_RESTART_MONITOR) begin
            clear_cond = clear_cond | ~monitor_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            service_due_o <= 1'b0;
        end else begin
            service_due_o <= (remaining_time == '0) & ~clear_cond;
        end
    end

    // Interrupt events, sticky until the status word is read
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            due_prev <= 1'b0;
            sat_prev <= 1'b0;
        end else begin
            due_prev <= service_due_o;
            sat_prev <= saturated;
        end
    end

    always_comb begin
        irq_events                   = '0;
        irq_events[`MHC_IRQ_DUE]     = service_due_o & ~due_prev;
        irq_events[`MHC_IRQ_RESTART] = restart_rise;
        irq_events[`MHC_IRQ_CLEAR]   = clear_rise;
        irq_events[`MHC_IRQ_SAT]     = saturated & ~sat_prev;
    end

    // A new event in the read cycle survives the clear
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat <= '0;
        end else if (rd_en && avs_address_i == `MHC_OFF_IRQ_STAT) begin
            irq_stat <= irq_events;
        end else begin
            irq_stat <= irq_stat | irq_events;
        end
    end

    assign irq_o = |(irq_stat & irq_mask);

    // Read data captured in the wait cycle, stands through the ack cycle
    always_comb begin
        case (avs_address_i)
            `MHC_OFF_RUN: begin
                next_readdata = {9'h0, accumulated_run_hours};
            end
            `MHC_OFF_REMAIN: begin
                next_readdata = {12'h0, remaining_time};
            end
            `MHC_OFF_STATE: begin
                next_readdata = {27'h0, saturated, clear_all_i, restart_i, monitor_i,
                                 service_due_o};
            end
            `MHC_OFF_IRQ_STAT: begin
                next_readdata = {28'h0, irq_stat};
            end
            default: begin
                next_readdata = cur_word;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata_o <= 32'h0;
        end else if (avs_read_i && !ack) begin
            avs_readdata_o <= next_readdata;
        end
    end
endmodule

// ==== common/mhc_map.svh ====
// Address map, field positions, limits and timing counts of the hours counter.
// Assumes a 32-bit Avalon-MM slave with byte addressing.
`ifndef MHC_MAP_SVH
`define MHC_MAP_SVH

// Register byte offsets
`define MHC_OFF_CTRL      5'h00
`define MHC_OFF_INTERVAL  5'h04
`define MHC_OFF_OFFSET    5'h08
`define MHC_OFF_RUN       5'h0C
`define MHC_OFF_REMAIN    5'h10
`define MHC_OFF_STATE     5'h14
`define MHC_OFF_IRQ_STAT  5'h18
`define MHC_OFF_IRQ_MASK  5'h1C

// CTRL fields
`define MHC_CTRL_POLICY_BIT  0
`define MHC_CTRL_SRC_LSB     8
`define MHC_CTRL_SRC_W       4

// INTERVAL and OFFSET fields: hours low, minutes high
`define MHC_INT_HOURS_W   14
`define MHC_OFS_HOURS_W   17
`define MHC_MINS_LSB      24
`define MHC_MINS_W        6

// Limits
`define MHC_INT_HOURS_MAX 14'h270F
`define MHC_OFS_HOURS_MAX 17'h1869F
`define MHC_MINS_MAX      6'h3B
`define MHC_MINS_PER_HOUR 8'h3C
`define MHC_RUN_LIMIT_MIN 23'h5B8D44
`define MHC_INT_MAX_MIN   20'h927BF

// Interval sources selectable by block number
`define MHC_SRC_N         8

// IRQ bits
`define MHC_IRQ_DUE       0
`define MHC_IRQ_RESTART   1
`define MHC_IRQ_CLEAR     2
`define MHC_IRQ_SAT       3
`define MHC_IRQ_W         4

// Time base: one minute, at a 250 MHz clock
`define MHC_MINUTE_S      60
`define MHC_CLK_HZ        250000000

`endif

// ==== common/mhc_pkg.sv ====
// Types shared by the hours counter design files.
// Assumes the fixed widths here hold the limits in mhc_map.svh.
`include "mhc_map.svh"

package mhc_pkg;
    typedef enum logic {
        MHC_RESTART_ONLY,
        MHC_RESTART_MONITOR
    } mhc_policy_t;

    typedef logic [22:0] mhc_run_t;
    typedef logic [19:0] mhc_remain_t;
endpackage

// ==== src/mhc_rise_det.sv ====
// Rising edge detector for one control input.
// Assumes the input is synchronous to the clock.
module mhc_rise_det (
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    input  wire logic level_i,
    output logic      rise_o
);
    logic prev;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev <= 1'b0;
        end else begin
            prev <= level_i;
        end
    end

    assign rise_o = level_i & ~prev;
endmodule

// ==== src/mhc_tick_gen.sv ====
// Minute tick generator that counts only enabled cycles.
// Assumes a synchronous enable; partial minutes are kept across pauses.
module mhc_tick_gen #(
    parameter logic [39:0] TICK_CYCLES = 40'h37E11D600
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    input  wire logic enable_i,
    output logic      tick_o
);
    logic [39:0] count;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count <= 40'h0;
        end else if (enable_i) begin
            if (count >= TICK_CYCLES - 40'h1) begin
                count <= 40'h0;
            end else begin
                count <= count + 40'h1;
            end
        end
    end

    assign tick_o = enable_i && (count >= TICK_CYCLES - 40'h1);
endmodule

// ==== testbench/mhc_top_chk.sv ====
// Concurrent checks on the hours counter top ports.
// Assumes one clock domain and bind to every mhc_top instance.
module mhc_top_chk (
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        monitor_i,
    input  wire logic        restart_i,
    input  wire logic        clear_all_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_readdata_o,
    input  wire logic        avs_waitrequest_o,
    input  wire logic        service_due_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_req_start;
        !(avs_read_i || avs_write_i) ##1 (avs_read_i || avs_write_i);
    endsequence
    sequence s_restart_edge;
        !restart_i ##1 restart_i;
    endsequence
    sequence s_clear_edge;
        !clear_all_i ##1 clear_all_i;
    endsequence
    // Writes may reload the remaining time, so they void the hold check
    sequence s_due_quiet;
        service_due_o && monitor_i && !restart_i && !clear_all_i
            && !avs_write_i && !$past(avs_write_i);
    endsequence

    a_wait_first: assert property (s_req_start |-> avs_waitrequest_o)
        else $error("no wait state in first request cycle");
    a_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
                                 |=> !avs_waitrequest_o)
        else $error("more than one wait state");
    a_rdata_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o))
        else $error("read data changed without a read");
    a_restart_clear: assert property (s_restart_edge |=> !service_due_o)
        else $error("restart edge did not clear output");
    a_fullclr_clear: assert property (s_clear_edge |=> !service_due_o)
        else $error("full clear edge did not clear output");
    a_restart_level: assert property (restart_i |=> !service_due_o)
        else $error("output high while restart held");
    a_clear_level: assert property (clear_all_i |=> !service_due_o)
        else $error("output high while full clear held");
    a_due_hold: assert property (s_due_quiet |=> service_due_o)
        else $error("output dropped without a reload");
    a_due_cause: assert property ($rose(service_due_o)
                                  |-> $past(!restart_i && !clear_all_i))
        else $error("output rose during a clear condition");
endmodule

bind mhc_top mhc_top_chk i_mhc_top_chk (
    .sys_clk_i        (sys_clk_i),
    .resetn_i         (resetn_i),
    .monitor_i        (monitor_i),
    .restart_i        (restart_i),
    .clear_all_i      (clear_all_i),
    .avs_read_i       (avs_read_i),
    .avs_write_i      (avs_write_i),
    .avs_readdata_o   (avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .service_due_o    (service_due_o)
);

// ==== testbench/mhc_src_model.sv ====
// Live actual values of the other function blocks, in minutes.
// Assumes source k sits at bits [(k-1)*32 +: 32]; values are fixed.
`include "mhc_map.svh"

module mhc_src_model (
    output logic [`MHC_SRC_N*32-1:0] src_values_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Distinct odd values so a wrong source pick shows up
    always_comb begin
        for (int j = 0; j < `MHC_SRC_N; j++) begin
            src_values_o[j*32 +: 32] = 32'(2 * j + 3);
        end
    end
endmodule

// ==== testbench/test_maintenance_hours_counter.sv ====
// Self-checking bench for the hours counter over its Avalon-MM slave.
// Assumes a four-cycle minute for speed; bus waits end only on waitrequest low.
`include "mhc_map.svh"

module test_maintenance_hours_counter;
    timeunit 1ns;
    timeprecision 1ps;
    logic                     sys_clk_i = 1'b0;
    logic                     resetn_i = 1'b0;
    logic                     monitor_i = 1'b0;
    logic                     restart_i = 1'b0;
    logic                     clear_all_i = 1'b0;
    logic [`MHC_SRC_N*32-1:0] src_values;
    logic [4:0]               avs_address_i = 5'h00;
    logic                     avs_read_i = 1'b0;
    logic                     avs_write_i = 1'b0;
    logic [31:0]              avs_writedata_i = 32'h0;
    logic [3:0]               avs_byteenable_i = 4'hF;
    logic [31:0]              avs_readdata_o;
    logic                     avs_waitrequest_o;
    logic                     service_due_o;
    logic                     irq_o;
    logic [31:0]              rd;
    int                       bad_count = 0;
    int                       n_checks = 0;

    always #2 sys_clk_i = ~sys_clk_i;

    mhc_src_model i_mhc_src_model (.src_values_o(src_values));
    mhc_top #(.MINUTE_CYCLES(40'h4)) i_mhc_top (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .monitor_i(monitor_i),
        .restart_i(restart_i), .clear_all_i(clear_all_i), .src_values_i(src_values),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .service_due_o(service_due_o),
        .irq_o(irq_o));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    // Request held until waitrequest is seen low; a hang is left to the watchdog
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        avs_read_i <= ~wr;
        avs_write_i <= wr;
        avs_address_i <= a;
        avs_writedata_i <= d;
        do begin
            @(posedge sys_clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    // Extra wait lets the tick reach the remaining time and the output
    task automatic mon(input int n);
        monitor_i <= 1'b1;
        cyc(n);
        monitor_i <= 1'b0;
        cyc(4);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        bad_count++;
        test_done();
    end

    initial begin
        cyc(12);
        resetn_i <= 1'b1;
        cyc(4);
        rdc(`MHC_OFF_CTRL, 32'h0);
        rdc(`MHC_OFF_INTERVAL, 32'h0);
        wr(5'h02, 32'hFFFFFFFF);
        rdc(5'h02, 32'h0);
        rdc(`MHC_OFF_CTRL, 32'h0);
        avs_byteenable_i <= 4'hE;
        wr(`MHC_OFF_IRQ_MASK, 32'hF);
        avs_byteenable_i <= 4'hF;
        rdc(`MHC_OFF_IRQ_MASK, 32'h0);
        wr(`MHC_OFF_IRQ_MASK, 32'h1);
        check({31'h0, service_due_o}, 32'h1);
        $display("test reset_registers done");
        wr(`MHC_OFF_INTERVAL, 32'h03000000);
        rdc(`MHC_OFF_REMAIN, 32'h3);
        mon(8);
        rdc(`MHC_OFF_REMAIN, 32'h1);
        rdc(`MHC_OFF_RUN, 32'h2);
        cyc(20);
        rdc(`MHC_OFF_REMAIN, 32'h1);
        mon(4);
        check({31'h0, service_due_o}, 32'h1);
        check({31'h0, irq_o}, 32'h1);
        mon(8);
        rdc(`MHC_OFF_REMAIN, 32'h0);
        rdc(`MHC_OFF_RUN, 32'h5);
        rdc(`MHC_OFF_IRQ_STAT, 32'h1);
        check({31'h0, irq_o}, 32'h0);
        $display("test count_down done");
        check({31'h0, service_due_o}, 32'h1);
        restart_i <= 1'b1;
        cyc(3);
        check({31'h0, service_due_o}, 32'h0);
        restart_i <= 1'b0;
        cyc(2);
        rdc(`MHC_OFF_REMAIN, 32'h3);
        rdc(`MHC_OFF_RUN, 32'h5);
        rdc(`MHC_OFF_IRQ_STAT, 32'h2);
        $display("test restart done");
        wr(`MHC_OFF_CTRL, 32'h1);
        monitor_i <= 1'b1;
        cyc(16);
        check({31'h0, service_due_o}, 32'h1);
        monitor_i <= 1'b0;
        cyc(3);
        check({31'h0, service_due_o}, 32'h0);
        monitor_i <= 1'b1;
        cyc(3);
        check({31'h0, service_due_o}, 32'h1);
        monitor_i <= 1'b0;
        cyc(2);
        rdc(`MHC_OFF_REMAIN, 32'h0);
        $display("test monitor_policy done");
        clear_all_i <= 1'b1;
        cyc(3);
        check({31'h0, service_due_o}, 32'h0);
        clear_all_i <= 1'b0;
        cyc(2);
        rdc(`MHC_OFF_RUN, 32'h0);
        rdc(`MHC_OFF_REMAIN, 32'h3);
        $display("test full_clear done");
        wr(`MHC_OFF_OFFSET, 32'h3B01869E);
        rdc(`MHC_OFF_RUN, 32'h005B8D43);
        mon(16);
        rdc(`MHC_OFF_RUN, 32'h005B8D44);
        rdc(`MHC_OFF_STATE, 32'h10);
        $display("test saturation done");
        wr(`MHC_OFF_CTRL, 32'h00000301);
        restart_i <= 1'b1;
        cyc(2);
        restart_i <= 1'b0;
        cyc(2);
        rdc(`MHC_OFF_REMAIN, 32'h7);
        wr(`MHC_OFF_CTRL, 32'h0);
        wr(`MHC_OFF_INTERVAL, 32'hFF003FFF);
        rdc(`MHC_OFF_REMAIN, 32'h000927BF);
        $display("test interval_source done");
        test_done();
    end
endmodule
